// >>> core/pem_pkg.sv
// Shared constants, register map and state types for the phase efficiency manager.
package pem_pkg;
	// Core clock rate in hertz (100 ns period).
	localparam int CLK_HZ = 10_000_000;
	// Largest number of populated multiphase channels.
	localparam int MAX_PH = 6;
	// Nominal per-channel switching frequencies in kilohertz.
	localparam int MP_FSW_KHZ = 200;
	localparam int SP_FSW_KHZ = 230;
	// Frequency trim gain in hertz per microamp sunk from the frequency set pins.
	localparam int MP_GAIN_HZ_PER_UA = 10_000;
	localparam int SP_GAIN_HZ_PER_UA = 11_500;
	// Frequency set pin voltage in millivolts; no logic reads it, the trim current comes from the register.
	localparam int FSET_PIN_MV = 1020;
	// Lowest apparent frequency in diode emulation, and the longest cycle it allows.
	localparam int DE_MIN_HZ = 30_000;
	localparam int DE_MAX_CYC = CLK_HZ / DE_MIN_HZ;
	// Shortest switching period accepted after trimming, in clock cycles.
	localparam int MIN_PER_CYC = 4;
	// Overcurrent reference and the millivolt weight of one sense code.
	localparam int VOCP_MV = 2500;
	localparam int CODE_LSB_MV = 10;
	localparam int VOCP_CODE = VOCP_MV / CODE_LSB_MV;
	// Wait before shedding may resume after a reset event.
	localparam int RESUME_US = 20;
	localparam int RESUME_CYC = RESUME_US * (CLK_HZ / 1_000_000);
	// Power state codes.
	localparam logic [7:0] PS_FULL = 8'h00;
	localparam logic [7:0] PS_REDUCED = 8'h01;
	// Phase ceiling while in the reduced power state.
	localparam logic [2:0] REDUCED_MAX_PH = 3'h2;
	// Register byte offsets.
	localparam int ADDR_W = 8;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_THR_A = 8'h04;
	localparam logic [7:0] REG_THR_B = 8'h08;
	localparam logic [7:0] REG_FSET = 8'h0c;
	localparam logic [7:0] REG_STATUS = 8'h10;
	// Control field positions.
	localparam int CTRL_SHED_EN = 0;
	localparam int CTRL_GDC_AUTO = 1;
	localparam int CTRL_NPH_LSB = 2;
	// Threshold B field positions.
	localparam int THRB_GDC_LSB = 8;
	localparam int THRB_HYST_LSB = 16;
	// Frequency trim field positions.
	localparam int FSET_SP_LSB = 8;
	// Reset values.
	localparam logic [31:0] CTRL_RST = 32'h0000_0019;
	localparam logic [31:0] THR_A_RST = 32'h6050_4030;
	localparam logic [31:0] THR_B_RST = 32'h0004_2070;
	localparam logic [31:0] FSET_RST = 32'h0000_0000;
	// Shedding controller states.
	typedef enum logic [1:0] {ST_FULL, ST_RUN, ST_HOLD} shed_st_t;
	// Per-channel PWM states.
	typedef enum logic [1:0] {PW_HI, PW_LO, PW_IDLE} pwm_st_t;
endpackage

// >>> core/pwm_cell.sv
// One PWM channel with continuous and diode-emulation firing.
`timescale 1ns/1ps
module pwm_cell (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_de,
	input wire logic i_fire,
	input wire logic [9:0] i_period,
	input wire logic [9:0] i_ton,
	output logic o_pwm,
	output logic o_pwm_oe
);
	import pem_pkg::*;

	// Whole state of the channel.
	typedef struct packed {
		pwm_st_t st;
		logic [9:0] cnt;
		logic [9:0] cyc;
		logic pwm;
		logic oe;
	} cell_t;

	cell_t s_r;
	cell_t s_nxt;
	logic [9:0] ton_c;
	logic [9:0] low_side_on_time;
	logic [9:0] cyc_lim;

	// On-time is kept inside the period so that a low phase always follows.
	assign ton_c = (i_ton == 10'h000) ? 10'h001 : ((i_ton >= i_period) ? i_period - 10'h001 : i_ton);
	assign low_side_on_time = i_period - ton_c;
	assign cyc_lim = 10'(DE_MAX_CYC);

	// Next-state logic for the firing sequence.
	always_comb begin
		s_nxt = s_r;
		s_nxt.cnt = s_r.cnt + 10'h001;
		s_nxt.cyc = s_r.cyc + 10'h001;
		case (s_r.st)
			PW_HI: begin
				// High side on for the normal on-time. [R08]
				if (s_r.cnt >= ton_c - 10'h001) begin
					s_nxt.st = PW_LO;
					s_nxt.cnt = 10'h000;
				end
			end
			PW_LO: begin
				// Low side on for the normal off-time, then release the pin in emulation. [R08]
				if (s_r.cnt >= low_side_on_time - 10'h001) begin
					s_nxt.cnt = 10'h000;
					// A period already at the floor fires again at once, so the idle
					// state is never entered with its cycle count past the limit.
					if (i_de && s_r.cyc < cyc_lim - 10'h001) begin
						s_nxt.st = PW_IDLE;
					end else begin
						s_nxt.st = PW_HI;
						s_nxt.cyc = 10'h000;
					end
				end
			end
			PW_IDLE: begin
				// Fire on demand, or when the cycle would drop below the audible floor. [R09]
				if (!i_de || i_fire || s_r.cyc >= cyc_lim - 10'h001) begin
					s_nxt.st = PW_HI;
					s_nxt.cnt = 10'h000;
					s_nxt.cyc = 10'h000;
				end
			end
			default: begin
				s_nxt.st = PW_HI;
				s_nxt.cnt = 10'h000;
			end
		endcase
		s_nxt.pwm = (s_nxt.st == PW_HI);
		s_nxt.oe = (s_nxt.st != PW_IDLE);
	end

	// State register; the pin comes out of reset driven low.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			s_r <= '{st: PW_LO, cnt: 10'h000, cyc: 10'h000, pwm: 1'b0, oe: 1'b1};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign o_pwm = s_r.pwm;
	assign o_pwm_oe = s_r.oe;

	// The released state never lasts past the audible floor.
	AST_DE_FLOOR: assert property (@(posedge i_clk) disable iff (i_rst)
		(s_r.st == PW_IDLE) |-> (s_r.cyc < cyc_lim)) // [R09]
		else $error("idle interval exceeded the frequency floor");
	// Leaving emulation restores a driven pin on the next edge.
	AST_HIZ_EXIT: assert property (@(posedge i_clk) disable iff (i_rst)
		(s_r.st == PW_IDLE && !i_de) |=> (o_pwm && o_pwm_oe)) // [R08]
		else $error("pin stayed released outside emulation");
endmodule

// >>> core/phase_efficiency_manager.sv
// Phase shedding, diode emulation, gate-drive select and frequency set for a dual buck.
`timescale 1ns/1ps
// Overview of operation
// R01: Drop phases as filtered load current falls.
// R02: Evaluate shedding only after regulator ready.
// R03: Voltage-set or transient restores all, then resumes.
// R04: Current-limit steps force phase count upward.
// R05: Current-limit check only adds phases.
// R06: Multiphase emulation only at one phase, zero-cross.
// R07: Single-phase emulates whenever inductor current reverses.
// R08: Emulation: on-time, off-time, then released pin.
// R09: Emulation cycle never slower than 30 kHz.
// R10: Gate supply switches between two driver rails.
// R11: Default high rail; low rail from reduced state.
// R12: Automatic threshold switches rail even at full.
// R13: Nominal 200/230 kHz; ripple is N times.
// R14: Frequency trimmed by pin current gain.
// R15: Reduced state forces shedding, one or two.
// R16: Shed from highest index, re-space interleave; the code sets no phase spacing.
// R17: Hysteresis between add and drop thresholds.
module phase_efficiency_manager (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [pem_pkg::ADDR_W-1:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	input wire logic [7:0] i_load_sense,
	input wire logic [7:0] i_fast_current_limit_sense_sense,
	input wire logic i_reg_ready,
	input wire logic i_transient_det,
	input wire logic i_mp_zero_cross,
	input wire logic i_sp_current_neg,
	input wire logic i_voltage_set_cmd,
	input wire logic [7:0] i_power_state,
	input wire logic [9:0] i_mp_ton,
	input wire logic [9:0] i_sp_ton,
	input wire logic i_mp_fire,
	input wire logic i_sp_fire,
	output logic [pem_pkg::MAX_PH-1:0] o_phase_en,
	output logic [2:0] o_active_phases,
	output logic [15:0] o_mp_ripple_khz,
	output logic [9:0] o_mp_period,
	output logic [9:0] o_sp_period,
	output logic o_mp_de,
	output logic o_sp_de,
	output logic o_gdc_low_rail,
	output logic o_mp_pwm,
	output logic o_mp_pwm_oe,
	output logic o_sp_pwm,
	output logic o_sp_pwm_oe
);
	import pem_pkg::*;

	// Whole state of the block, synchronisers included.
	typedef struct packed {
		logic [31:0] ctrl;
		logic [31:0] thr_a;
		logic [31:0] thr_b;
		logic [31:0] fset;
		logic [31:0] rdata;
		logic [7:0] ld1;
		logic [7:0] ld2;
		logic [7:0] il1;
		logic [7:0] il2;
		logic [3:0] pin1;
		logic [3:0] pin2;
		logic tr_prev;
		shed_st_t st;
		logic [2:0] act;
		logic [9:0] dly;
		logic [MAX_PH-1:0] phen;
		logic [15:0] rip;
		logic [9:0] mp_per;
		logic [9:0] sp_per;
		logic mp_de;
		logic sp_de;
		logic gate_drive_supply_select;
	} state_t;

	state_t s_r;
	state_t s_nxt;

	// Synchronised pin levels: ready, transient, zero-cross, current sign.
	logic pg_s;
	logic tr_s;
	logic zc_s;
	logic sn_s;
	assign pg_s = s_r.pin2[0];
	assign tr_s = s_r.pin2[1];
	assign zc_s = s_r.pin2[2];
	assign sn_s = s_r.pin2[3];

	// Decoded configuration.
	logic [2:0] nph_raw;
	logic [2:0] nph;
	logic reduced;
	logic shed_on;
	logic [2:0] cap;
	logic reset_ev;
	logic [11:0] il_steps;
	logic [2:0] fast_current_limit_sense_req;
	logic [7:0] hyst;
	logic [7:0] gdc_thr;

	// Threshold between k and k+1 phases, k from 1 to 5.
	function automatic logic [7:0] thr_of(input logic [2:0] k, input logic [31:0] a,
			input logic [31:0] b);
		logic [7:0] t;
		case (k)
			3'h1: t = a[7:0];
			3'h2: t = a[15:8];
			3'h3: t = a[23:16];
			3'h4: t = a[31:24];
			default: t = b[7:0];
		endcase
		return t;
	endfunction

	// Channel period in clock cycles from nominal frequency and signed trim current.
	function automatic logic [9:0] per_of(input int base_khz, input int gain,
			input logic signed [7:0] trim);
		int f;
		int p;
		f = base_khz * 1000 + gain * int'(trim);
		if (f < DE_MIN_HZ) begin
			f = DE_MIN_HZ;
		end
		p = CLK_HZ / f;
		if (p < MIN_PER_CYC) begin
			p = MIN_PER_CYC;
		end
		return p[9:0];
	endfunction

	// Enable mask that keeps the lowest-indexed phases on.
	function automatic logic [MAX_PH-1:0] therm(input logic [2:0] n);
		logic [MAX_PH-1:0] m;
		m = '0;
		for (int i = 0; i < MAX_PH; i++) begin
			m[i] = (3'(i) < n);
		end
		return m;
	endfunction

	// A populated count of zero is read as one; above the maximum is clipped.
	assign nph_raw = s_r.ctrl[CTRL_NPH_LSB+:3];
	assign nph = (nph_raw == 3'h0) ? 3'h1 : ((nph_raw > 3'(MAX_PH)) ? 3'(MAX_PH) : nph_raw);
	// Reduced power state forces shedding and a two-phase ceiling. [R15]
	assign reduced = (i_power_state >= PS_REDUCED);
	assign shed_on = s_r.ctrl[CTRL_SHED_EN] | reduced;
	assign cap = (reduced && nph > REDUCED_MAX_PH) ? REDUCED_MAX_PH : nph;
	// A rising transient edge or a voltage-set command cancels shedding. [R03]
	assign reset_ev = i_voltage_set_cmd | (tr_s & ~s_r.tr_prev);
	// The sense step is the limit level over half the step width, plus one: step = il*2N/Vref + 1. [R04]
	assign il_steps = 12'((int'(s_r.il2) * 2 * int'(nph)) / VOCP_CODE + 1);
	assign fast_current_limit_sense_req = (il_steps > 12'(cap)) ? cap : il_steps[2:0];
	assign hyst = s_r.thr_b[THRB_HYST_LSB+:8];
	assign gdc_thr = s_r.thr_b[THRB_GDC_LSB+:8];

	// All next-state logic: bus, synchronisers, shedding and outputs.
	always_comb begin
		s_nxt = s_r;
		// Pins pass two flops; only the second is read by logic.
		s_nxt.pin1 = {i_sp_current_neg, i_mp_zero_cross, i_transient_det, i_reg_ready};
		s_nxt.pin2 = s_r.pin1;
		s_nxt.ld1 = i_load_sense;
		s_nxt.ld2 = s_r.ld1;
		s_nxt.il1 = i_fast_current_limit_sense_sense;
		s_nxt.il2 = s_r.il1;
		s_nxt.tr_prev = tr_s;
		// Register writes; unmapped offsets are ignored.
		if (i_wr) begin
			case (i_addr)
				REG_CTRL: s_nxt.ctrl = i_wdata;
				REG_THR_A: s_nxt.thr_a = i_wdata;
				REG_THR_B: s_nxt.thr_b = i_wdata;
				REG_FSET: s_nxt.fset = i_wdata;
				default: begin
				end
			endcase
		end
		// Read data stands for one cycle only; unmapped offsets read zero.
		s_nxt.rdata = 32'h0000_0000;
		if (i_rd) begin
			case (i_addr)
				REG_CTRL: s_nxt.rdata = s_r.ctrl;
				REG_THR_A: s_nxt.rdata = s_r.thr_a;
				REG_THR_B: s_nxt.rdata = s_r.thr_b;
				REG_FSET: s_nxt.rdata = s_r.fset;
				REG_STATUS: s_nxt.rdata = {24'h00_0000, s_r.st, s_r.gate_drive_supply_select, s_r.sp_de, s_r.mp_de,
					s_r.act};
				default: s_nxt.rdata = 32'h0000_0000;
			endcase
		end
		// Shedding controller.
		case (s_r.st)
			ST_FULL: begin
				// Soft-start and disabled shedding run with every phase. [R02]
				s_nxt.act = nph;
				if (pg_s && shed_on) begin
					s_nxt.st = ST_RUN;
				end
			end
			ST_RUN: begin
				if (!shed_on || !pg_s) begin
					s_nxt.st = ST_FULL;
					s_nxt.act = nph;
				end else if (reset_ev) begin
					// Restore all phases and wait before shedding again. [R03]
					s_nxt.st = ST_HOLD;
					s_nxt.act = nph;
					s_nxt.dly = 10'(RESUME_CYC);
				end else if (fast_current_limit_sense_req > s_r.act) begin
					// The fast limit sense only ever raises the count. [R04] [R05]
					s_nxt.act = fast_current_limit_sense_req;
				end else if (s_r.act > cap) begin
					s_nxt.act = s_r.act - 3'h1;
				end else if (s_r.act < cap && s_r.ld2 >= thr_of(s_r.act, s_r.thr_a, s_r.thr_b)) begin
					// Add one phase at the threshold above the present count. [R01]
					s_nxt.act = s_r.act + 3'h1;
				end else if (s_r.act > fast_current_limit_sense_req && {1'b0, s_r.ld2} + {1'b0, hyst} <
						{1'b0, thr_of(s_r.act - 3'h1, s_r.thr_a, s_r.thr_b)}) begin
					// Drop under the hysteresis band, never below the limit step. [R01] [R05] [R17]
					s_nxt.act = s_r.act - 3'h1;
				end
			end
			ST_HOLD: begin
				s_nxt.act = nph;
				if (!shed_on || !pg_s) begin
					s_nxt.st = ST_FULL;
				end else if (reset_ev) begin
					s_nxt.dly = 10'(RESUME_CYC);
				end else if (s_r.dly == 10'h000) begin
					// Resume; the load check then decides if shedding is compatible. [R03]
					s_nxt.st = ST_RUN;
				end else begin
					s_nxt.dly = s_r.dly - 10'h001;
				end
			end
			default: begin
				s_nxt.st = ST_FULL;
				s_nxt.act = nph;
			end
		endcase
		// Highest index goes first; the count sets the enable mask. [R16]
		s_nxt.phen = therm(s_nxt.act);
		// Load-side ripple is the count times the nominal multiphase channel frequency, untrimmed. [R13]
		s_nxt.rip = 16'(int'(s_nxt.act) * MP_FSW_KHZ);
		// Trimmed periods at 200 and 230 kHz nominal. [R13] [R14]
		s_nxt.mp_per = per_of(MP_FSW_KHZ, MP_GAIN_HZ_PER_UA, s_r.fset[7:0]);
		s_nxt.sp_per = per_of(SP_FSW_KHZ, SP_GAIN_HZ_PER_UA, s_r.fset[FSET_SP_LSB+:8]);
		// Multiphase emulation needs shedding down to one phase and a zero cross. [R06]
		s_nxt.mp_de = (s_nxt.st == ST_RUN) && (s_nxt.act == 3'h1) && zc_s;
		// Single-phase emulation follows the inductor current sign alone. [R07]
		s_nxt.sp_de = sn_s;
		// Low rail in reduced state, or under the automatic threshold. [R10] [R11] [R12]
		s_nxt.gate_drive_supply_select = reduced | (s_r.ctrl[CTRL_GDC_AUTO] & (s_r.ld2 < gdc_thr));
	end

	// State register; reset comes up with all phases and the high driver rail.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			s_r <= '{ctrl: CTRL_RST, thr_a: THR_A_RST, thr_b: THR_B_RST, fset: FSET_RST,
				rdata: 32'h0000_0000, ld1: 8'h00, ld2: 8'h00, il1: 8'h00, il2: 8'h00,
				pin1: 4'h0, pin2: 4'h0, tr_prev: 1'b0, st: ST_FULL, act: 3'(MAX_PH),
				dly: 10'h000, phen: {MAX_PH{1'b1}}, rip: 16'h0000, mp_per: 10'h032,
				sp_per: 10'h02b, mp_de: 1'b0, sp_de: 1'b0, gate_drive_supply_select: 1'b0};
		end else begin
			s_r <= s_nxt;
		end
	end

	// Phase 1 carries the multiphase emulation pattern; other phases stay continuous.
	pwm_cell u_mp_cell (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_de(s_r.mp_de),
		.i_fire(i_mp_fire),
		.i_period(s_r.mp_per),
		.i_ton(i_mp_ton),
		.o_pwm(o_mp_pwm),
		.o_pwm_oe(o_mp_pwm_oe)
	);

	// Single-phase section channel.
	pwm_cell u_sp_cell (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_de(s_r.sp_de),
		.i_fire(i_sp_fire),
		.i_period(s_r.sp_per),
		.i_ton(i_sp_ton),
		.o_pwm(o_sp_pwm),
		.o_pwm_oe(o_sp_pwm_oe)
	);

	assign o_rdata = s_r.rdata;
	assign o_phase_en = s_r.phen;
	assign o_active_phases = s_r.act;
	assign o_mp_ripple_khz = s_r.rip;
	assign o_mp_period = s_r.mp_per;
	assign o_sp_period = s_r.sp_per;
	assign o_mp_de = s_r.mp_de;
	assign o_sp_de = s_r.sp_de;
	assign o_gdc_low_rail = s_r.gate_drive_supply_select;

	// A reset event in the shedding state, then all phases and a hold.
	sequence seq_shed_reset;
		(s_r.st == ST_RUN) && shed_on && pg_s && reset_ev;
	endsequence
	sequence seq_restored;
		(s_r.st == ST_HOLD) && (s_r.act == nph) && (s_r.dly == 10'(RESUME_CYC));
	endsequence

	AST_FULL_BEFORE_READY: assert property (@(posedge i_clk) disable iff (i_rst)
		(s_r.st == ST_FULL) |-> (o_phase_en == therm(nph) || $changed(nph))) // [R02]
		else $error("phases shed before shedding was allowed");
	AST_RESET_RESTORES: assert property (@(posedge i_clk) disable iff (i_rst)
		seq_shed_reset |=> seq_restored) // [R03]
		else $error("reset event did not restore all phases");
	AST_HOLD_BOUND: assert property (@(posedge i_clk) disable iff (i_rst)
		(s_r.st == ST_HOLD && s_r.dly == 10'h000 && shed_on && pg_s && !reset_ev)
		|=> (s_r.st == ST_RUN)) // [R03]
		else $error("shedding did not resume after the delay");
	AST_FAST_CURRENT_LIMIT_SENSE_ADD: assert property (@(posedge i_clk) disable iff (i_rst)
		(s_r.st == ST_RUN && shed_on && pg_s && !reset_ev && fast_current_limit_sense_req > s_r.act)
		|=> (s_r.act == $past(fast_current_limit_sense_req))) // [R04]
		else $error("limit sense did not raise the phase count");
	AST_DROP_ONE: assert property (@(posedge i_clk) disable iff (i_rst)
		($past(s_r.st) == ST_RUN && s_r.st == ST_RUN && s_r.act < $past(s_r.act))
		|-> ($past(s_r.act) - s_r.act == 3'h1)) // [R05]
		else $error("phase count fell by more than one step");
	AST_MP_DE_ONE: assert property (@(posedge i_clk) disable iff (i_rst)
		o_mp_de |-> (o_active_phases == 3'h1 && o_phase_en == 6'h01)) // [R06]
		else $error("multiphase emulation with more than one phase");
	AST_SP_DE: assert property (@(posedge i_clk) disable iff (i_rst)
		sn_s |=> o_sp_de) // [R07]
		else $error("single-phase emulation missed a current reversal");
	AST_GDC_REDUCED: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_power_state >= PS_REDUCED) |=> o_gdc_low_rail) // [R11]
		else $error("reduced state kept the high driver rail");
	AST_GDC_DEFAULT: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_power_state == PS_FULL && !s_r.ctrl[CTRL_GDC_AUTO]) |=> !o_gdc_low_rail) // [R11]
		else $error("full state left the high driver rail");
	AST_RIPPLE: assert property (@(posedge i_clk) disable iff (i_rst)
		$changed(o_active_phases) |-> (o_mp_ripple_khz == 16'(int'(o_active_phases) * MP_FSW_KHZ))) // [R13]
		else $error("ripple frequency does not track the phase count");
endmodule

// >>> verification/gate_drive_model.sv
// Behavioural external gate driver that watches one PWM pin and times its released intervals.
`timescale 1ns/1ps
module gate_drive_model (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_pwm,
	input wire logic i_pwm_oe,
	input wire logic i_clr,
	output logic o_pin,
	output logic [9:0] o_idle,
	output logic [9:0] o_max_idle
);
	// The pin level and the length of the current and longest released stretch.
	// A released pin has no defined level, so the model toggles it every cycle
	// instead of letting the simulator settle it to a convenient value.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_pin <= 1'b0;
			o_idle <= 10'h000;
			o_max_idle <= 10'h000;
		end else if (i_pwm_oe) begin
			// Driven pin: the driver follows the controller level.
			o_pin <= i_pwm;
			o_idle <= 10'h000;
		end else begin
			// Released pin: both switches stay off while it floats.
			o_pin <= ~o_pin;
			o_idle <= o_idle + 10'h001;
			if (o_idle + 10'h001 > o_max_idle) begin
				o_max_idle <= o_idle + 10'h001; // Longest gap bounds the frequency.
			end
		end
		if (i_clr) begin
			o_max_idle <= 10'h000;
		end
	end
endmodule

// >>> verification/phase_efficiency_manager_tb.sv
// Self-checking bench for the phase efficiency manager.
`timescale 1ns/1ps
module phase_efficiency_manager_tb;
	import pem_pkg::*;
	logic i_clk = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0, rd_q = 1'b0, probe = 1'b0;
	logic [7:0] i_addr = 8'h00, i_load_sense = 8'h00, i_fast_current_limit_sense_sense = 8'h00, i_power_state = 8'h00;
	logic [31:0] i_wdata = 32'h0000_0000, seed = 32'h0000_004f;
	logic i_reg_ready = 1'b0, i_transient_det = 1'b0, i_mp_zero_cross = 1'b0;
	logic i_sp_current_neg = 1'b0, i_voltage_set_cmd = 1'b0, i_mp_fire = 1'b0, i_sp_fire = 1'b0;
	logic [9:0] i_mp_ton = 10'h00a, i_sp_ton = 10'h00a, idle, max_idle, o_mp_period, o_sp_period;
	logic [31:0] o_rdata;
	logic [MAX_PH-1:0] o_phase_en;
	logic [2:0] o_active_phases;
	logic [15:0] o_mp_ripple_khz;
	logic o_mp_de, o_sp_de, o_gdc_low_rail, o_mp_pwm, o_mp_pwm_oe, o_sp_pwm, o_sp_pwm_oe;
	logic clr = 1'b0;
	int error_cnt = 0, num_checks = 0;
	// Each expectation names the output to look at and the value it must hold.
	typedef struct {int sel; logic [31:0] exp;} note_t;
	note_t notes[$];
	always #50 i_clk = ~i_clk;
	phase_efficiency_manager uut (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_load_sense(i_load_sense),
		.i_fast_current_limit_sense_sense(i_fast_current_limit_sense_sense), .i_reg_ready(i_reg_ready), .i_transient_det(i_transient_det),
		.i_mp_zero_cross(i_mp_zero_cross), .i_sp_current_neg(i_sp_current_neg),
		.i_voltage_set_cmd(i_voltage_set_cmd), .i_power_state(i_power_state), .i_mp_ton(i_mp_ton),
		.i_sp_ton(i_sp_ton), .i_mp_fire(i_mp_fire), .i_sp_fire(i_sp_fire), .o_phase_en(o_phase_en),
		.o_active_phases(o_active_phases), .o_mp_ripple_khz(o_mp_ripple_khz),
		.o_mp_period(o_mp_period), .o_sp_period(o_sp_period), .o_mp_de(o_mp_de), .o_sp_de(o_sp_de),
		.o_gdc_low_rail(o_gdc_low_rail), .o_mp_pwm(o_mp_pwm), .o_mp_pwm_oe(o_mp_pwm_oe),
		.o_sp_pwm(o_sp_pwm), .o_sp_pwm_oe(o_sp_pwm_oe));
	// The far-side driver on the single-phase PWM pin.
	gate_drive_model drv (.i_clk(i_clk), .i_rst(i_rst), .i_pwm(o_sp_pwm), .i_pwm_oe(o_sp_pwm_oe),
		.i_clr(clr), .o_pin(), .o_idle(idle), .o_max_idle(max_idle));
	// Picks the watched output; read data stands only the cycle after a read strobe.
	function automatic logic [31:0] seen(input int s);
		case (s)
			0: seen = o_rdata;
			1: seen = {29'h0, o_active_phases};
			2: seen = {26'h0, o_phase_en};
			3: seen = {31'h0, o_mp_de};
			4: seen = {31'h0, o_sp_de};
			5: seen = {31'h0, o_gdc_low_rail};
			6: seen = {16'h0, o_mp_ripple_khz};
			7: seen = {22'h0, o_mp_period};
			8: seen = {22'h0, o_sp_period};
			10: seen = {22'h0, max_idle};
			11: seen = {30'h0, o_mp_pwm, o_mp_pwm_oe};
			default: seen = {30'h0, o_sp_pwm, o_sp_pwm_oe};
		endcase
	endfunction
	function automatic logic [31:0] xs(input logic [31:0] v);
		v = v ^ (v << 13);
		v = v ^ (v >> 17);
		xs = v ^ (v << 5);
	endfunction
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR at %0t: saw %h, expected %h", $time, got, exp);
		end
	endtask
	// Watcher: reads answer one cycle after the strobe, other notes at their probe cycle.
	always @(posedge i_clk) rd_q <= i_rd;
	always @(negedge i_clk) begin
		if (rd_q || probe) begin
			if (notes.size() == 0) begin
				check(32'h0, 32'h1);
			end else begin
				check(seen(notes[0].sel), notes[0].exp);
				void'(notes.pop_front());
			end
		end
	end
	task automatic tic(input int n);
		repeat (n) @(posedge i_clk);
	endtask
	task automatic note(input int s, input logic [31:0] e);
		notes.push_back('{s, e});
		probe <= 1'b1;
		@(posedge i_clk);
		probe <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		i_rd <= 1'b1;
		i_addr <= a;
		notes.push_back('{0, e});
		@(posedge i_clk);
		i_rd <= 1'b0;
		@(posedge i_clk);
	endtask
	task automatic done(input string t);
		$display("test %s finished", t);
	endtask
	task automatic end_of_test();
		tic(2);
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// Watchdog sized well above the roughly fifteen hundred cycles the tests need.
	initial begin
		#(100 * 20000);
		error_cnt++;
		end_of_test();
	end
	initial begin
		tic(3);
		i_rst <= 1'b0;
		tic(3);
		note(1, 32'h6);
		note(2, 32'h3f);
		note(5, 32'h0);
		note(6, 32'd1200);
		note(7, 32'd50);
		note(8, 32'd43);
		note(11, 32'h1);
		rd(REG_CTRL, CTRL_RST);
		rd(REG_THR_A, THR_A_RST);
		rd(REG_THR_B, THR_B_RST);
		rd(8'h14, 32'h0);
		wr(REG_STATUS, 32'hffff_ffff);
		rd(REG_STATUS, 32'h6);
		done("reset");
		// Shedding waits for regulator ready, then walks down one phase a cycle.
		tic(10);
		note(1, 32'h6);
		i_reg_ready <= 1'b1;
		tic(20);
		note(1, 32'h1);
		note(2, 32'h01);
		note(6, 32'd200);
		rd(REG_STATUS, 32'h41);
		for (int k = 0; k < 4; k++) begin
			seed = xs(seed);
			i_load_sense <= seed[7:0] % 8'h2c;
			tic(8);
			note(1, 32'h1);
		end
		i_load_sense <= 8'h30;
		tic(8);
		note(1, 32'h2);
		note(2, 32'h03);
		note(6, 32'd400);
		i_load_sense <= 8'h2d;
		tic(8);
		note(1, 32'h2);
		i_load_sense <= 8'h2b;
		tic(8);
		note(1, 32'h1);
		done("shedding");
		// Current-limit step above the one-phase step adds a phase, never removes one.
		i_load_sense <= 8'h00;
		seed = xs(seed);
		i_fast_current_limit_sense_sense <= 8'd21 + seed[7:0] % 8'd21;
		tic(8);
		note(1, 32'h2);
		i_fast_current_limit_sense_sense <= 8'h00;
		tic(8);
		note(1, 32'h1);
		done("limit");
		// Zero-cross at one phase enters emulation; both reset events restore all phases.
		i_mp_zero_cross <= 1'b1;
		tic(6);
		note(3, 32'h1);
		for (int e = 0; e < 2; e++) begin
			if (e == 0) begin
				i_voltage_set_cmd <= 1'b1;
				tic(1);
				i_voltage_set_cmd <= 1'b0;
			end else begin
				i_transient_det <= 1'b1;
			end
			tic(6);
			note(1, 32'h6);
			note(3, 32'h0);
			i_transient_det <= 1'b0;
			tic(140);
			note(1, 32'h6);
			tic(100);
			note(1, 32'h1);
		end
		done("reset events");
		// Single-phase emulation: released pin, bounded gap, a firing ends the gap.
		i_sp_current_neg <= 1'b1;
		tic(6);
		note(4, 32'h1);
		clr <= 1'b1;
		tic(1);
		clr <= 1'b0;
		tic(800);
		note(10, 32'(DE_MAX_CYC - CLK_HZ / (SP_FSW_KHZ * 1000)));
		for (int w = 0; w < 400 && idle < 10'd20; w++) begin
			tic(1);
		end
		note(9, 32'h0);
		i_sp_fire <= 1'b1;
		tic(1);
		i_sp_fire <= 1'b0;
		tic(2);
		note(9, 32'h3);
		done("emulation");
		// Gate-drive rail by power state and by the automatic threshold.
		i_load_sense <= 8'hff;
		i_power_state <= PS_REDUCED;
		tic(12);
		note(5, 32'h1);
		note(1, 32'h2);
		i_power_state <= 8'h02;
		tic(4);
		note(5, 32'h1);
		i_power_state <= PS_FULL;
		tic(12);
		note(5, 32'h0);
		note(1, 32'h6);
		wr(REG_CTRL, 32'h0000_001b);
		i_load_sense <= 8'h10;
		tic(8);
		note(5, 32'h1);
		i_load_sense <= 8'h30;
		tic(8);
		note(5, 32'h0);
		done("rail");
		// Frequency trim: plus five microamps gives 250 kHz, minus ten gives 100 kHz.
		wr(REG_FSET, 32'h0000_0005);
		tic(4);
		note(7, 32'd40);
		wr(REG_FSET, 32'h0000_00f6);
		tic(4);
		note(7, 32'd100);
		note(8, 32'd43);
		rd(REG_FSET, 32'h0000_00f6);
		done("frequency");
		end_of_test();
	end
endmodule
